// ---- core/hps_sequencer.sv ----
// haptic playback power sequencer with apb register access
// How it works
// - boost and amplifier enabled as soon as a sample write wakes us; playback starts 2 ms later.
// - output path shuts down cleanly when data stops or the buffer underruns.
// - after idle timeout, a non-zero held output ramps toward 0x00.
// - sample bytes written during the ramp are discarded.
// - without override, enables are on only while playback needs them.
// - without force, first sample reaches the converter only after wake-up completes.
// - force bit starts power-up at once and holds enables on.
// - with force set, samples play with no wake-up delay.
// - standby bit rising enters the lowest-power standby state.
// - while standby is set every other mode stays disabled.
// - standby bit falling readies the device to accept samples.
// - soft reset aborts activity, restores defaults, enters standby.
// - two-bit range code picks 25/50/75/100 V peak, analog gain to match.
// - over-temperature disables boost and amp; resumes once cool again.
// - brownout shuts down and resets to defaults at once, holding them until supply recovers.
// - one buffered sample per 8 kHz tick goes to the converter.
// - samples are signed: 0x7f top, 0x80 bottom, 0x00 mid-scale.
`timescale 1ns/10ps
module hps_sequencer #(
    parameter int WAKE_CYCLES = hps_pkg::WAKE_CYC,
    parameter int TICK_CYCLES = hps_pkg::TICK_CYC,
    parameter int IDLE_TICKS = hps_pkg::IDLE_TICKS,
    parameter int FIFO_DEPTH = hps_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic over_temp,
    input wire logic brownout_threshold,
    output logic boost_en,
    output logic amp_en,
    output logic [1:0] gain_sel,
    output logic [7:0] dac_code,
    output logic dac_strobe
);
    localparam int AW = 7;

    typedef struct packed {
        hps_pkg::hps_state_e st;
        hps_pkg::hps_ctrl_s ctrl;
        logic [22:0] cnt;
        logic [15:0] tick;
        logic [7:0] idle;
        logic [7:0] dac;
        logic strobe;
        logic pwr;
        logic drop_seen;
    } hps_seq_s;

    hps_seq_s s_q, s_d;
    hps_pkg::hps_apb_req_s req;
    logic acc, wr, rd, fifo_wr, fifo_rd, flush, tick_hit;
    logic [7:0] fifo_data;
    logic fifo_empty, fifo_full;
    logic [AW:0] fifo_level;
    logic mapped;

    // one step toward mid-scale, sign-aware for two's complement
    function automatic logic [7:0] toward_mid(input logic [7:0] v);
        if (v == hps_pkg::MID_CODE) toward_mid = v;
        else if (v[7]) toward_mid = v + 8'h01; // negative climbs up
        else toward_mid = v - 8'h01;
    endfunction

    assign req = '{psel, penable, pwrite, paddr, pwdata};
    assign acc = req.psel && req.penable;
    assign wr = acc && req.pwrite;
    assign rd = acc && !req.pwrite;
    assign pready = 1'b1; // zero wait states
    assign mapped = (req.paddr == hps_pkg::ADDR_CTRL) ||
                    (req.paddr == hps_pkg::ADDR_FIFO) ||
                    (req.paddr == hps_pkg::ADDR_STATUS) ||
                    (req.paddr == hps_pkg::ADDR_OUT);
    assign pslverr = acc && !mapped;
    assign tick_hit = (s_q.tick == 16'(TICK_CYCLES - 1));

    // sample byte write; dropped in standby, ramp and hazard states
    assign fifo_wr = wr && (req.paddr == hps_pkg::ADDR_FIFO) &&
                     !s_q.ctrl.standby &&
                     (s_q.st != hps_pkg::ST_RAMP) &&
                     !over_temp && !brownout_threshold;

    // flush on soft reset, brownout or standby
    always_comb begin
        flush = brownout_threshold || s_q.ctrl.standby;
        if (wr && req.paddr == hps_pkg::ADDR_CTRL &&
            req.pwdata[hps_pkg::CTRL_SRST]) flush = 1'b1;
    end

    // drain one byte per tick while playing
    assign fifo_rd = tick_hit && !fifo_empty && !over_temp &&
                     ((s_q.st == hps_pkg::ST_PLAY) ||
                      (s_q.st == hps_pkg::ST_WAIT));

    hps_fifo #(
        .DEPTH(FIFO_DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(flush),
        .wr_en(fifo_wr),
        .wr_data(req.pwdata[7:0]),
        .rd_en(fifo_rd),
        .rd_data(fifo_data),
        .empty(fifo_empty),
        .full(fifo_full),
        .level(fifo_level)
    );

    // read mux; reserved bits read zero
    always_comb begin
        prdata = '0;
        if (rd) begin
            unique case (req.paddr)
                hps_pkg::ADDR_CTRL: begin
                    prdata[hps_pkg::CTRL_STANDBY] = s_q.ctrl.standby;
                    prdata[hps_pkg::CTRL_FORCE] = s_q.ctrl.force_power_on;
                    prdata[hps_pkg::CTRL_GAIN_HI:hps_pkg::CTRL_GAIN_LO] =
                        s_q.ctrl.gain;
                end
                hps_pkg::ADDR_STATUS: begin
                    prdata[2:0] = s_q.st;
                    prdata[3] = fifo_empty;
                    prdata[4] = fifo_full;
                    prdata[5] = s_q.pwr;
                    prdata[6] = over_temp;
                    prdata[7] = s_q.drop_seen;
                    prdata[15:8] = 8'(fifo_level);
                end
                hps_pkg::ADDR_OUT: prdata[7:0] = s_q.dac;
                default: prdata = '0;
            endcase
        end
    end

    // sequencer next state
    always_comb begin
        s_d = s_q;
        s_d.strobe = 1'b0;
        s_d.tick = tick_hit ? '0 : s_q.tick + 16'h0001;
        if (wr && req.paddr == hps_pkg::ADDR_FIFO && !fifo_wr)
            s_d.drop_seen = 1'b1;
        // control writes
        if (wr && req.paddr == hps_pkg::ADDR_CTRL) begin
            s_d.ctrl.standby = req.pwdata[hps_pkg::CTRL_STANDBY];
            s_d.ctrl.force_power_on = req.pwdata[hps_pkg::CTRL_FORCE];
            s_d.ctrl.gain = req.pwdata[hps_pkg::CTRL_GAIN_HI:
                                       hps_pkg::CTRL_GAIN_LO];
            s_d.drop_seen = 1'b0;
        end
        unique case (s_q.st)
            hps_pkg::ST_STANDBY: begin
                s_d.pwr = 1'b0;
                s_d.dac = hps_pkg::MID_CODE;
                if (!s_q.ctrl.standby) s_d.st = hps_pkg::ST_IDLE;
            end
            hps_pkg::ST_IDLE: begin
                s_d.pwr = 1'b0;
                if (s_q.ctrl.force_power_on) begin
                    s_d.st = hps_pkg::ST_WAKE;
                    s_d.cnt = '0;
                end else if (!fifo_empty) begin
                    s_d.st = hps_pkg::ST_WAKE;
                    s_d.cnt = '0;
                end
            end
            hps_pkg::ST_WAKE: begin
                s_d.pwr = 1'b1;
                s_d.cnt = s_q.cnt + 23'h000001;
                if (s_q.cnt == 23'(WAKE_CYCLES - 1)) begin
                    s_d.st = hps_pkg::ST_PLAY;
                    s_d.tick = '0;
                end
            end
            hps_pkg::ST_PLAY: begin
                if (fifo_rd) begin
                    s_d.dac = fifo_data;
                    s_d.strobe = 1'b1;
                end else if (tick_hit && fifo_empty) begin
                    s_d.st = hps_pkg::ST_WAIT;
                    s_d.idle = '0;
                end
            end
            hps_pkg::ST_WAIT: begin
                if (fifo_rd) begin
                    s_d.dac = fifo_data;
                    s_d.strobe = 1'b1;
                    s_d.st = hps_pkg::ST_PLAY;
                end else if (tick_hit) begin
                    s_d.idle = s_q.idle + 8'h01;
                    if (s_q.idle == 8'(IDLE_TICKS - 1)) begin
                        if (s_q.dac != hps_pkg::MID_CODE)
                            s_d.st = hps_pkg::ST_RAMP;
                        else if (!s_q.ctrl.force_power_on)
                            s_d.st = hps_pkg::ST_IDLE;
                    end
                end
            end
            hps_pkg::ST_RAMP: begin
                if (tick_hit) begin
                    s_d.dac = toward_mid(s_q.dac);
                    s_d.strobe = 1'b1;
                    if (toward_mid(s_q.dac) == hps_pkg::MID_CODE)
                        s_d.st = s_q.ctrl.force_power_on ?
                                 hps_pkg::ST_WAIT : hps_pkg::ST_IDLE;
                    s_d.idle = '0;
                end
            end
            default: s_d.st = hps_pkg::ST_STANDBY;
        endcase
        // with force set, power stays up and the wake wait is skipped
        if (s_q.ctrl.force_power_on && s_q.pwr &&
            s_d.st == hps_pkg::ST_WAKE) s_d.st = hps_pkg::ST_PLAY;
        // entering idle (timeout or ramp done, force off): drop power
        if (s_d.st == hps_pkg::ST_IDLE) s_d.pwr = 1'b0;
        // standby entry overrides next state, power and counters
        if (s_d.ctrl.standby) begin
            s_d.st = hps_pkg::ST_STANDBY;
            s_d.pwr = 1'b0;
            s_d.idle = '0;
            s_d.cnt = '0;
        end
        // soft reset restores defaults and lands in standby
        if (wr && req.paddr == hps_pkg::ADDR_CTRL &&
            req.pwdata[hps_pkg::CTRL_SRST]) begin
            s_d = '0;
            s_d.ctrl.standby = hps_pkg::STANDBY_RST;
            s_d.ctrl.gain = hps_pkg::GAIN_RST;
            s_d.st = hps_pkg::ST_STANDBY;
        end
        // brownout: shut down and hold defaults until supply returns
        if (brownout_threshold) begin
            s_d = '0;
            s_d.ctrl.standby = hps_pkg::STANDBY_RST;
            s_d.ctrl.gain = hps_pkg::GAIN_RST;
            s_d.st = hps_pkg::ST_STANDBY;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl.standby <= hps_pkg::STANDBY_RST;
            s_q.st <= hps_pkg::ST_STANDBY;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; thermal trip gates enables but leaves state intact
    assign boost_en = (s_q.pwr || s_q.ctrl.force_power_on) &&
                      !s_q.ctrl.standby && !over_temp;
    assign amp_en = boost_en;
    assign gain_sel = s_q.ctrl.gain;
    assign dac_code = s_q.dac;
    assign dac_strobe = s_q.strobe;
endmodule

// ---- shared/hps_pkg.sv ----
// package: register map, state encoding and timing constants of the sequencer
package hps_pkg;
    // apb register offsets, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FIFO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OUT = 8'h0c;
    // control register field positions
    localparam int CTRL_STANDBY = 0;
    localparam int CTRL_FORCE = 1;
    localparam int CTRL_SRST = 2;
    localparam int CTRL_GAIN_LO = 3;
    localparam int CTRL_GAIN_HI = 4;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic STANDBY_RST = 1'b1;
    // mid-scale code and full-scale limits, two's complement
    localparam logic [7:0] MID_CODE = 8'h00;
    localparam logic [7:0] POS_FS = 8'h7f;
    localparam logic [7:0] NEG_FS = 8'h80;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_HZ = 8_000;
    localparam int TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int WAKE_US = 2000;
    localparam int WAKE_CYC = (CLK_HZ / 1_000_000) * WAKE_US;
    localparam int IDLE_TICKS = 16;
    localparam int FIFO_DEPTH = 100;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_IDLE = 3'b001,
        ST_WAKE = 3'b010,
        ST_PLAY = 3'b011,
        ST_WAIT = 3'b100,
        ST_RAMP = 3'b101
    } hps_state_e;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } hps_apb_req_s;

    // software-controlled bits
    typedef struct packed {
        logic standby;
        logic force_power_on;
        logic [1:0] gain;
    } hps_ctrl_s;
endpackage

// ---- core/hps_fifo.sv ----
// sample buffer holding written bytes until the tick consumes them
`timescale 1ns/10ps
module hps_fifo #(
    parameter int DEPTH = 100,
    parameter int AW = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic empty,
    output logic full,
    output logic [AW:0] level
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } hps_fifo_s;

    logic [7:0] mem [DEPTH];
    hps_fifo_s s_q, s_d;
    logic do_wr, do_rd;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign empty = (s_q.cnt == '0);
    assign full = (s_q.cnt == (AW+1)'(DEPTH));
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;
    assign rd_data = mem[s_q.rp];
    assign level = s_q.cnt;

    // pointer and count update; flush wins over any access
    always_comb begin
        s_d = s_q;
        if (flush) begin
            s_d = '0;
        end else begin
            if (do_wr) s_d.wp = bump(s_q.wp);
            if (do_rd) s_d.rp = bump(s_q.rp);
            if (do_wr && !do_rd) s_d.cnt = s_q.cnt + 1'b1;
            if (do_rd && !do_wr) s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) s_q <= '0;
        else s_q <= s_d;
    end

    // storage has no reset, contents are gated by the count
    always_ff @(posedge clk_sys) begin
        if (do_wr && !flush) mem[s_q.wp] <= wr_data;
    end
endmodule

// ---- testbench/hps_seq_props.sv ----
// checker: port-level assertions for the playback sequencer
`timescale 1ns/10ps
module hps_seq_props #(
    parameter int WAKE_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic over_temp,
    input wire logic brownout_threshold,
    input wire logic boost_en,
    input wire logic amp_en,
    input wire logic [1:0] gain_sel,
    input wire logic [7:0] dac_code,
    input wire logic dac_strobe
);
    logic [15:0] pwr_cnt_q;
    logic ctrl_wr;
    // time powered; saturates so a long force hold never wraps
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_cnt_q <= 16'h0000;
        end else if (!boost_en) begin
            pwr_cnt_q <= 16'h0000;
        end else if (pwr_cnt_q != 16'hffff) begin
            pwr_cnt_q <= pwr_cnt_q + 16'h0001;
        end
    end
    // control write that a brownout does not override
    assign ctrl_wr = psel && penable && pwrite && !brownout_threshold
        && paddr == hps_pkg::ADDR_CTRL;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    en_pair_a: assert property (boost_en == amp_en)
        else $error("enables differ");
    hot_off_a: assert property (over_temp |-> !boost_en)
        else $error("powered while hot");
    brown_off_a: assert property (brownout_threshold |=>
        !boost_en && dac_code == 8'h00 && gain_sel == 2'h0)
        else $error("brownout left state");
    strobe_gap_a: assert property (dac_strobe |=> !dac_strobe [*8])
        else $error("strobes too close");
    wake_wait_a: assert property (dac_strobe |->
        pwr_cnt_q >= WAKE_CYCLES)
        else $error("sample before wake-up");
    gain_wr_a: assert property (ctrl_wr && !pwdata[2] |=>
        gain_sel == $past(pwdata[4:3]))
        else $error("gain not taken");
    soft_rst_a: assert property (ctrl_wr && pwdata[2] |=>
        gain_sel == 2'h0 && !boost_en && dac_code == 8'h00)
        else $error("soft reset incomplete");
    standby_off_a: assert property (ctrl_wr && pwdata[0] |=>
        !boost_en) else $error("powered in standby");
    cover property (dac_strobe && dac_code == 8'h00);
    cover property ($rose(boost_en));
    cover property (ctrl_wr && pwdata[2]);
endmodule

// ---- testbench/hps_host.sv ----
// host model: apb master standing in for the serial bus host
`timescale 1ns/10ps
module hps_host (
    input wire logic clk_sys,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output hps_pkg::hps_apb_req_s req
);
    initial req = '0;
    // setup, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req <= '0;
        // idle edge so the next request never lands on the release
        @(posedge clk_sys);
    endtask
endmodule

// ---- testbench/hps_sequencer_test.sv ----
// testbench: apb-driven scenarios for the playback sequencer
`timescale 1ns/10ps
`define CHK(act, want) begin \
    num_checks++; \
    if ((act) !== (want)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (want)); \
    end \
end
module hps_sequencer_test;
    localparam int WAKE = 20;
    logic clk_sys, rst_n, over_temp, brownout_threshold, e;
    logic pready, pslverr, boost_en, amp_en, dac_strobe;
    logic [31:0] prdata, r;
    logic [1:0] gain_sel;
    logic [7:0] dac_code;
    hps_pkg::hps_apb_req_s req;
    int mismatches = 0, num_checks = 0, cyc = 0, n = 0;
    hps_host i_host (.clk_sys(clk_sys), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req));
    hps_sequencer #(.WAKE_CYCLES(WAKE), .TICK_CYCLES(10), .IDLE_TICKS(3),
        .FIFO_DEPTH(100)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite),
        .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .over_temp(over_temp),
        .brownout_threshold(brownout_threshold), .boost_en(boost_en),
        .amp_en(amp_en), .gain_sel(gain_sel), .dac_code(dac_code),
        .dac_strobe(dac_strobe));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a);
        i_host.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // bounded wait; a strobe that never comes is an error
    task automatic wait_strobe();
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (dac_strobe !== 1'b1 && n < 200);
        if (n >= 200) mismatches++;
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // watchdog well past the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        over_temp = 1'b0;
        brownout_threshold = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // defaults, then an unmapped address
        rd(hps_pkg::ADDR_CTRL);
        `CHK(r, 32'h0000_0001)
        rd(hps_pkg::ADDR_STATUS);
        `CHK(r[2:0], 3'h0)
        rd(8'h40);
        `CHK(e, 1'b1)
        for (int g = 0; g < 4; g++) begin
            wr(hps_pkg::ADDR_CTRL, 32'(g) << 3);
            `CHK(gain_sel, 2'(g))
        end
        rd(hps_pkg::ADDR_STATUS);
        `CHK(r[2:0], 3'h1)
        // signed samples, the last left off mid-scale to force a ramp
        wr(hps_pkg::ADDR_FIFO, 32'hffff_ff05);
        wr(hps_pkg::ADDR_FIFO, 32'h0000_00fe);
        `CHK(boost_en, 1'b1)
        wait_strobe();
        `CHK(n > WAKE, 1'b1)
        `CHK(dac_code, 8'h05)
        wait_strobe();
        `CHK(dac_code, 8'hfe)
        wait_strobe();
        `CHK(dac_code, 8'hff)
        wr(hps_pkg::ADDR_FIFO, 32'h33);
        wait_strobe();
        `CHK(dac_code, 8'h00)
        n = 0;
        while (boost_en !== 1'b0 && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(boost_en, 1'b0)
        rd(hps_pkg::ADDR_STATUS);
        `CHK(r[15:0], 16'h0089)
        // forced power, through a thermal trip
        wr(hps_pkg::ADDR_CTRL, 32'h2);
        `CHK(boost_en, 1'b1)
        over_temp <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(amp_en, 1'b0)
        over_temp <= 1'b0;
        repeat (WAKE + 5) @(posedge clk_sys);
        `CHK(amp_en, 1'b1)
        wr(hps_pkg::ADDR_FIFO, 32'h11);
        wait_strobe();
        `CHK(n < WAKE, 1'b1)
        `CHK(dac_code, 8'h11)
        // standby over force: all off, samples refused
        wr(hps_pkg::ADDR_CTRL, 32'h3);
        `CHK(boost_en, 1'b0)
        wr(hps_pkg::ADDR_FIFO, 32'h22);
        rd(hps_pkg::ADDR_STATUS);
        `CHK({r[15:8], r[2:0]}, 11'h000)
        wr(hps_pkg::ADDR_CTRL, 32'h0);
        rd(hps_pkg::ADDR_STATUS);
        `CHK(r[2:0], 3'h1)
        wr(hps_pkg::ADDR_CTRL, 32'h18);
        wr(hps_pkg::ADDR_CTRL, 32'h4);
        `CHK(gain_sel, 2'h0)
        rd(hps_pkg::ADDR_CTRL);
        `CHK(r, 32'h0000_0001)
        // brownout in mid-wake
        wr(hps_pkg::ADDR_CTRL, 32'h10);
        wr(hps_pkg::ADDR_FIFO, 32'h40);
        brownout_threshold <= 1'b1;
        repeat (2) @(posedge clk_sys);
        brownout_threshold <= 1'b0;
        @(posedge clk_sys);
        `CHK(gain_sel, 2'h0)
        rd(hps_pkg::ADDR_STATUS);
        `CHK({r[15:8], r[5], r[2:0]}, 12'h000)
        finish_test();
    end
endmodule
bind hps_sequencer hps_seq_props #(.WAKE_CYCLES(WAKE_CYCLES)) i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .over_temp(over_temp),
    .brownout_threshold(brownout_threshold), .boost_en(boost_en),
    .amp_en(amp_en), .gain_sel(gain_sel), .dac_code(dac_code),
    .dac_strobe(dac_strobe));
